//--- hdl/branch_bitset_params.svh
// constants for the relative branch and bit set execution block
`ifndef BRANCH_BITSET_PARAMS_SVH
`define BRANCH_BITSET_PARAMS_SVH

// program counter width, reset value and sequential step
`define PC_W 21
`define PC_RESET 21'h000000
`define PC_STEP 21'h000002

// opcode fields
`define OPC_BRANCH_NZ 8'hE1
`define OPC_BRANCH_ALWAYS 5'h1A
`define OPC_BIT_SET 4'h8
`define OPC_SKIP_CLR 4'hB
`define OPC_SKIP_SET 4'hA

// instruction field positions
`define BIT_MSB 11
`define BIT_LSB 9
`define ACC_POS 8

// data addressing
`define IDX_LIMIT 8'h5F
`define ACCESS_SPLIT 8'h60
`define ACCESS_LO_BANK 4'h0
`define ACCESS_HI_BANK 4'hF

// reset values of the datapath registers
`define WORD_RESET 16'h0000
`define ADDR_RESET 12'h000
`define DATA_RESET 8'h00

`endif

//--- hdl/branch_bitset_pkg.sv
// types shared by the relative branch and bit set execution block
package branch_bitset_pkg;

	typedef enum logic [1:0] {
		ph_q1 = 2'b00,
		ph_q2 = 2'b01,
		ph_q3 = 2'b10,
		ph_q4 = 2'b11
	} phase_t;

	typedef enum logic [2:0] {
		op_nop = 3'b000,
		op_branch_nz = 3'b001,
		op_branch_always = 3'b010,
		op_bit_set = 3'b011,
		op_skip_clr = 3'b100,
		op_skip_set = 3'b101
	} op_t;

endpackage : branch_bitset_pkg

//--- hdl/relative_branch_and_bit_set_exec.sv
// execution of relative branches, bit set and bit test skip
`timescale 1ns/1ps
`include "branch_bitset_params.svh"

// =============================================================
// Overview of operation
// - opcode E1 with signed 8-bit n is branch_not_zero, taken on zero 0
// - a taken branch adds twice the signed operand to the program counter
// - target is branch address plus 2 plus twice the operand
// - branch_not_zero: one cycle, two when taken; extra cycle is a nop
// - with zero set, program counter moves to branch address plus 4
// - prefix 11010 with signed 11-bit n decodes as branch_always
// - branch_always loads incremented pc plus twice the operand
// - branch_always takes two cycles, written in Q4, second cycle a nop
// - opcode 1000 bbba ffff ffff sets bit b of register f
// - access flag 0 selects the fixed access bank
// - access flag 1 forms the address from bank_select_register and f
// - extended set, access flag 0, f up to 95 uses indexed literal offset
// - bit test skips use the same f, b, access flag format
// - opcode 1011 is bit_test_skip_clear, skipping when the bit is 0
// - opcode 1010 is bit_test_skip_set, skipping when the bit is 1
// - a skip discards the fetched word and runs a nop instead
// =============================================================
module relative_branch_and_bit_set_exec
(
	input wire logic core_clk, // core clock, 125 MHz
	input wire logic reset, // synchronous reset, active high
	input wire logic [15:0] instr_word, // prefetched word, held through Q1
	input wire logic zero_flag, // zero status bit
	input wire logic [3:0] bank_select_register, // data bank number
	input wire logic ext_set_en, // extended instruction set enabled
	input wire logic [11:0] index_base, // base for indexed literal offset
	input wire logic [7:0] data_rd_data, // register file read data
	output logic [`PC_W-1:0] pc, // program counter
	output branch_bitset_pkg::phase_t phase, // current quarter of the cycle
	output logic word_discard, // this cycle executes as a nop
	output logic [11:0] data_addr, // register file address
	output logic data_rd_en, // register file read strobe, Q2
	output logic data_wr_en, // register file write strobe, Q4
	output logic [7:0] data_wr_data, // register file write data
	output logic flag_write_en // status flag update, never raised
);
	import branch_bitset_pkg::*;

	// =========================================================
	// state
	phase_t phase_reg, phase_next;
	op_t op_reg, op_next;
	logic [`PC_W-1:0] pc_reg, pc_next;
	logic nop_pending_reg, nop_pending_next;
	logic [15:0] ir_reg, ir_next;
	logic [11:0] addr_reg, addr_next;
	logic [7:0] data_reg, data_next;
	logic wr_en_reg, wr_en_next;

	// =========================================================
	// decode
	op_t op_dec;
	logic [7:0] f_dec;
	logic acc_dec;
	logic [11:0] addr_dec;
	logic [2:0] bit_sel;
	logic [7:0] bit_mask;
	logic [`PC_W-1:0] off_short;
	logic [`PC_W-1:0] off_long;
	logic test_bit;
	logic skip;
	logic taken;

	always_comb begin
		f_dec = instr_word[7:0];
		acc_dec = instr_word[`ACC_POS];
		op_dec = op_nop;
		if (instr_word[15:8] == `OPC_BRANCH_NZ) begin
			op_dec = op_branch_nz;
		end else if (instr_word[15:11] == `OPC_BRANCH_ALWAYS) begin
			op_dec = op_branch_always;
		end else if (instr_word[15:12] == `OPC_BIT_SET) begin
			op_dec = op_bit_set;
		end else if (instr_word[15:12] == `OPC_SKIP_CLR) begin
			op_dec = op_skip_clr;
		end else if (instr_word[15:12] == `OPC_SKIP_SET) begin
			op_dec = op_skip_set;
		end
		// one address path serves bit set and both bit tests
		if (acc_dec) begin
			addr_dec = {bank_select_register, f_dec};
		end else if (ext_set_en && f_dec <= `IDX_LIMIT) begin
			addr_dec = index_base + {4'h0, f_dec};
		end else if (f_dec < `ACCESS_SPLIT) begin
			addr_dec = {`ACCESS_LO_BANK, f_dec};
		end else begin
			addr_dec = {`ACCESS_HI_BANK, f_dec};
		end
	end

	assign bit_sel = ir_reg[`BIT_MSB:`BIT_LSB];
	assign bit_mask = 8'h01 << bit_sel;
	// offsets are twice the signed operand, sign extended to the pc width
	assign off_short = {{12{ir_reg[7]}}, ir_reg[7:0], 1'b0};
	assign off_long = {{9{ir_reg[10]}}, ir_reg[10:0], 1'b0};
	assign test_bit = |(data_reg & bit_mask);
	assign skip = (op_reg == op_skip_clr && !test_bit) ||
		(op_reg == op_skip_set && test_bit);
	assign taken = op_reg == op_branch_always ||
		(op_reg == op_branch_nz && !zero_flag);

	// =========================================================
	// sequencing
	always_comb begin
		phase_next = phase_reg;
		op_next = op_reg;
		pc_next = pc_reg;
		nop_pending_next = nop_pending_reg;
		ir_next = ir_reg;
		addr_next = addr_reg;
		data_next = data_reg;
		wr_en_next = 1'b0;
		case (phase_reg)
			ph_q1: begin
				phase_next = ph_q2;
				// a discarded word is decoded as a nop
				if (nop_pending_reg) begin
					op_next = op_nop;
					ir_next = `WORD_RESET;
				end else begin
					op_next = op_dec;
					ir_next = instr_word;
					addr_next = addr_dec;
				end
			end
			ph_q2: begin
				phase_next = ph_q3;
				data_next = data_rd_data;
			end
			ph_q3: begin
				phase_next = ph_q4;
				if (op_reg == op_bit_set) begin
					data_next = data_reg | bit_mask;
					wr_en_next = 1'b1;
				end
			end
			ph_q4: begin
				phase_next = ph_q1;
				// pc already points past the branch word here
				if (op_reg == op_branch_always) begin
					pc_next = pc_reg + off_long;
				end else if (taken) begin
					pc_next = pc_reg + off_short;
				end else begin
					pc_next = pc_reg + `PC_STEP;
				end
				// after a taken branch or a skip, the word prefetched this cycle is never executed
				nop_pending_next = taken || skip;
			end
			default: begin
				phase_next = ph_q1;
			end
		endcase
	end

	always_ff @(posedge core_clk) begin
		if (reset) begin
			phase_reg <= ph_q1;
			op_reg <= op_nop;
			pc_reg <= `PC_RESET;
			// nothing is prefetched yet, so the first cycle is a nop
			nop_pending_reg <= 1'b1;
			ir_reg <= `WORD_RESET;
			addr_reg <= `ADDR_RESET;
			data_reg <= `DATA_RESET;
			wr_en_reg <= 1'b0;
		end else begin
			phase_reg <= phase_next;
			op_reg <= op_next;
			pc_reg <= pc_next;
			nop_pending_reg <= nop_pending_next;
			ir_reg <= ir_next;
			addr_reg <= addr_next;
			data_reg <= data_next;
			wr_en_reg <= wr_en_next;
		end
	end

	// =========================================================
	// outputs
	assign pc = pc_reg;
	assign phase = phase_reg;
	assign word_discard = nop_pending_reg;
	assign data_addr = addr_reg;
	assign data_rd_en = phase_reg == ph_q2 && (op_reg == op_bit_set ||
		op_reg == op_skip_clr || op_reg == op_skip_set);
	assign data_wr_en = wr_en_reg;
	assign data_wr_data = data_reg;
	assign flag_write_en = 1'b0;

	// =========================================================
	// checks
	default clocking cb @(posedge core_clk); endclocking
	default disable iff (reset);

	property p_nz_taken;
		phase_reg == ph_q4 && op_reg == op_branch_nz && !zero_flag |=>
			pc_reg == $past(pc_reg) + $past(off_short);
	endproperty
	a_nz_taken: assert property (p_nz_taken)
		else $error("branch_not_zero target wrong");

	property p_nz_fall;
		phase_reg == ph_q4 && op_reg == op_branch_nz && zero_flag |=>
			pc_reg == $past(pc_reg) + `PC_STEP ##1 !nop_pending_reg;
	endproperty
	a_nz_fall: assert property (p_nz_fall)
		else $error("untaken branch_not_zero did not fall through");

	property p_always_target;
		phase_reg == ph_q4 && op_reg == op_branch_always |=>
			pc_reg == $past(pc_reg) + $past(off_long);
	endproperty
	a_always_target: assert property (p_always_target)
		else $error("branch_always target wrong");

	property p_taken_nop;
		phase_reg == ph_q4 && taken |=>
			(nop_pending_reg && op_reg != op_bit_set) [*2] ##1
			op_reg == op_nop;
	endproperty
	a_taken_nop: assert property (p_taken_nop)
		else $error("cycle after a taken branch not a nop");

	property p_set_write;
		phase_reg == ph_q3 && op_reg == op_bit_set |=>
			data_wr_en && phase_reg == ph_q4 &&
			(data_wr_data & bit_mask) == bit_mask;
	endproperty
	a_set_write: assert property (p_set_write)
		else $error("bit_set_file write missing in Q4");

	property p_write_q4;
		data_wr_en |-> phase_reg == ph_q4 && op_reg == op_bit_set;
	endproperty
	a_write_q4: assert property (p_write_q4)
		else $error("register write outside Q4 of bit_set_file");

	property p_banked_addr;
		phase_reg == ph_q1 && !nop_pending_reg && instr_word[`ACC_POS] &&
			op_dec == op_bit_set |=>
			data_addr == {$past(bank_select_register), $past(instr_word[7:0])};
	endproperty
	a_banked_addr: assert property (p_banked_addr)
		else $error("banked address wrong");

	property p_indexed_addr;
		phase_reg == ph_q1 && !nop_pending_reg && !instr_word[`ACC_POS] &&
			ext_set_en && instr_word[7:0] <= `IDX_LIMIT |=>
			data_addr == $past(index_base) + {4'h0, $past(instr_word[7:0])};
	endproperty
	a_indexed_addr: assert property (p_indexed_addr)
		else $error("indexed literal offset address wrong");

	property p_skip;
		phase_reg == ph_q4 && skip |=>
			pc_reg == $past(pc_reg) + `PC_STEP && nop_pending_reg;
	endproperty
	a_skip: assert property (p_skip)
		else $error("skip did not discard the next word");

endmodule : relative_branch_and_bit_set_exec

//--- testbench/prog_data_model.sv
// program memory and register file facing the execution block
`timescale 1ns/1ps
// ==========================================
// far side model
module prog_data_model
(
	input wire logic core_clk, // core clock
	input wire logic reset, // synchronous reset
	input wire logic [20:0] pc, // next fetch address
	input wire branch_bitset_pkg::phase_t phase, // quarter of the cycle
	output logic [15:0] instr_word, // word shown in Q1
	input wire logic [11:0] data_addr, // register address
	input wire logic data_rd_en, // read strobe
	input wire logic data_wr_en, // write strobe
	input wire logic [7:0] data_wr_data, // write data
	output logic [7:0] data_rd_data // read data
);
	import branch_bitset_pkg::*;
	logic [15:0] mem [256];
	logic [7:0] rf [4096];
	logic [20:0] fetch_reg;
	initial for (int i = 0; i < 4096; i++) rf[i] = 8'(i * 37 + 5);
	always @(posedge core_clk) begin
		if (reset)
			fetch_reg <= 21'h000000;
		else if (phase == ph_q4)
			fetch_reg <= pc;
		if (data_wr_en)
			rf[data_addr] <= data_wr_data;
	end
	// outside its slot each bus shows the inverse, so a late sample is seen
	assign instr_word = (phase == ph_q1) ? mem[fetch_reg[8:1]]
		: ~mem[fetch_reg[8:1]];
	assign data_rd_data = data_rd_en ? rf[data_addr] : ~rf[data_addr];
endmodule : prog_data_model

//--- testbench/tb_relative_branch_and_bit_set_exec.sv
// self-checking bench for the relative branch and bit set block
`timescale 1ns/1ps
// ==========================================
// bench top
module tb_relative_branch_and_bit_set_exec;
	import branch_bitset_pkg::*;
	logic core_clk = 1'b0;
	logic reset = 1'b1;
	logic zero_flag = 1'b0;
	logic [3:0] bank_select_register = 4'h0;
	logic ext_set_en = 1'b0;
	logic [11:0] index_base = 12'h000;
	logic [15:0] instr_word;
	logic [7:0] data_rd_data, data_wr_data;
	logic [20:0] pc;
	phase_t phase;
	logic word_discard, data_rd_en, data_wr_en, flag_write_en, mdisc, bitop;
	logic [11:0] data_addr;
	logic [15:0] cur;
	logic [31:0] r;
	logic [7:0] mrf [4096];
	logic [15:0] prog [256];
	int error_cnt = 0;
	int checks = 0;
	int seed = 32'h27f4d387;
	int mpc, addr, nxt;
	always #4 core_clk = ~core_clk;
	relative_branch_and_bit_set_exec DUT (.core_clk(core_clk), .reset(reset),
		.instr_word(instr_word), .zero_flag(zero_flag),
		.bank_select_register(bank_select_register), .ext_set_en(ext_set_en),
		.index_base(index_base), .data_rd_data(data_rd_data), .pc(pc),
		.phase(phase), .word_discard(word_discard), .data_addr(data_addr),
		.data_rd_en(data_rd_en), .data_wr_en(data_wr_en),
		.data_wr_data(data_wr_data), .flag_write_en(flag_write_en));
	prog_data_model u_far (.core_clk(core_clk), .reset(reset), .pc(pc),
		.phase(phase), .instr_word(instr_word), .data_addr(data_addr),
		.data_rd_en(data_rd_en), .data_wr_en(data_wr_en),
		.data_wr_data(data_wr_data), .data_rd_data(data_rd_data));
	// ==========================================
	// helpers
	task automatic check(input logic [31:0] seen, input logic [31:0] exp);
		checks++;
		if (seen !== exp) begin
			error_cnt++;
			$display("[FAIL] t=%0t seen=%h exp=%h", $time, seen, exp);
		end
	endtask : check
	task automatic print_verdict();
		$display("checks=%0d mismatches=%0d", checks, error_cnt);
		if (error_cnt == 0 && checks > 0)
			$display("Run complete: PASS");
		else
			$display("Run complete: FAIL");
		$finish;
	endtask : print_verdict
	task automatic tick();
		@(posedge core_clk);
		#1;
	endtask : tick
	// boundary operands and the access split are favoured over pure noise
	function automatic logic [15:0] gen_word();
		logic [7:0] f;
		r = $random(seed);
		f = (r[9:8] == 2'h0) ? 8'h5F : ((r[9:8] == 2'h1) ? 8'h60 : r[31:24]);
		case (r[2:0])
			3'h0: gen_word = {8'hE1, r[4] ? {r[5], {7{~r[5]}}} : r[23:16]};
			3'h1: gen_word = {5'h1A, r[4] ? {r[5], {10{~r[5]}}} : r[26:16]};
			3'h2, 3'h5: gen_word = {4'h8, r[12:10], r[3], f};
			3'h3: gen_word = {4'hB, r[12:10], r[3], f};
			3'h4: gen_word = {4'hA, r[12:10], r[3], f};
			default: gen_word = r[31:16];
		endcase
	endfunction : gen_word
	function automatic int eff_addr(input logic [15:0] w);
		if (w[8])
			return {bank_select_register, w[7:0]};
		if (ext_set_en && w[7:0] <= 8'h5F)
			return (index_base + w[7:0]) & 12'hFFF;
		return {(w[7:0] < 8'h60) ? 4'h0 : 4'hF, w[7:0]};
	endfunction : eff_addr
	// model of one instruction cycle, evaluated while the design sits in Q4
	task automatic step();
		logic [7:0] mask;
		logic hit, take, skip, wr;
		int off;
		nxt = (mpc + 2) & 32'h1FFFFF;
		addr = eff_addr(cur);
		mask = 8'h01 << cur[11:9];
		hit = mrf[addr][cur[11:9]];
		off = $signed(cur[7:0]);
		if (cur[15:11] == 5'h1A)
			off = $signed(cur[10:0]);
		take = !mdisc && (cur[15:11] == 5'h1A ||
			(cur[15:8] == 8'hE1 && !zero_flag));
		skip = !mdisc && ((cur[15:12] == 4'hB && !hit) ||
			(cur[15:12] == 4'hA && hit));
		wr = !mdisc && cur[15:12] == 4'h8;
		check(data_wr_en, wr);
		if (wr) begin
			check(data_addr, addr);
			check(data_wr_data, mrf[addr] | mask);
			mrf[addr] = mrf[addr] | mask;
		end
		if (take)
			nxt = (mpc + 2 * off) & 32'h1FFFFF;
		mdisc = take || skip;
		cur = prog[(mpc >> 1) & 255];
		mpc = nxt;
	endtask : step
	// random program, one instruction cycle per pass, entered in Q4
	task automatic run_program();
		mpc = 0;
		mdisc = 1'b1;
		cur = 16'h0000;
		for (int c = 0; c < 400; c++) begin
			check(pc, mpc);
			check(phase, ph_q4);
			check(flag_write_en, 1'b0);
			step();
			tick();
			check(pc, mpc);
			check(word_discard, mdisc);
			r = $random(seed);
			zero_flag = r[0];
			ext_set_en = r[1];
			bank_select_register = r[7:4];
			index_base = r[27:16];
			tick();
			bitop = !mdisc && (cur[15:12] inside {4'h8, 4'hA, 4'hB});
			check(data_rd_en, bitop);
			if (bitop)
				check(data_addr, eff_addr(cur));
			tick();
			tick();
		end
		$display("random program test done after 400 instruction cycles");
	endtask : run_program
	// ==========================================
	// main sequence
	initial begin
		for (int i = 0; i < 256; i++) begin
			prog[i] = gen_word();
			u_far.mem[i] = prog[i];
		end
		for (int i = 0; i < 4096; i++) mrf[i] = 8'(i * 37 + 5);
		repeat (16) @(posedge core_clk);
		#1 reset = 1'b0;
		for (int k = 0; k < 20 && phase !== ph_q4; k++) tick();
		// a phase counter that never reaches Q4 is a lost run
		if (phase !== ph_q4) begin
			error_cnt++;
		end else begin
			run_program();
		end
		print_verdict();
	end
endmodule : tb_relative_branch_and_bit_set_exec
